/* design/pcss_pkg.sv */
package pcss_pkg;
    // AXI4-Lite geometry
    localparam int AXI_AW = 16;
    localparam int AXI_DW = 32;
    localparam int AXI_SW = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register byte offsets within the block
    localparam logic [AXI_AW-1:0] OFF_CTRL = 16'h1800;
    localparam logic [AXI_AW-1:0] OFF_SLEEP = 16'h1804;
    localparam logic [AXI_AW-1:0] OFF_STATUS = 16'h1808;

    // Implemented widths and reset values
    localparam int CTRL_W = 8;
    localparam int SLEEP_W = 2;
    localparam int STATUS_W = 14;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [SLEEP_W-1:0] SLEEP_RESET = 2'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 14'h0000;

    // socket_control fields
    localparam int C_RST0 = 0;
    localparam int C_RST1 = 1;
    localparam int C_FLT0 = 2;
    localparam int C_FLT1 = 3;
    localparam int C_WAIT0 = 4;
    localparam int C_WAIT1 = 5;
    localparam int C_VSEL_LO = 6;
    localparam int C_VSEL_HI = 7;

    // socket_sleep_state fields
    localparam int SL_SOCK0 = 0;
    localparam int SL_SOCK1 = 1;

    // socket_status fields
    localparam int ST_RDY0 = 0;
    localparam int ST_RDY1 = 1;
    localparam int ST_CDV0 = 2;
    localparam int ST_CDV1 = 3;
    localparam int ST_VS1_0 = 4;
    localparam int ST_VS2_0 = 5;
    localparam int ST_VS1_1 = 6;
    localparam int ST_VS2_1 = 7;
    localparam int ST_WP0 = 8;
    localparam int ST_WP1 = 9;
    localparam int ST_BVD1_0 = 10;
    localparam int ST_BVD2_0 = 11;
    localparam int ST_BVD1_1 = 12;
    localparam int ST_BVD2_1 = 13;

    // Card-side pin groups
    localparam int DATA_W = 16;
    localparam int HOST_AW = 26;
    localparam int S0_AW = 26;
    localparam int S1_AW = 11;
    localparam int STB_W = 7;
    localparam int STB_OE = 0;
    localparam int STB_IOR = 1;
    localparam int STB_IOW = 2;
    localparam int STB_CE1 = 3;
    localparam int STB_CE2 = 4;
    localparam int STB_WE = 5;
    localparam int STB_REG = 6;

    // Per-socket card input vector
    localparam int IN_W = 9;
    localparam int IN_RDY = 0;
    localparam int IN_CD1 = 1;
    localparam int IN_CD2 = 2;
    localparam int IN_VS1 = 3;
    localparam int IN_VS2 = 4;
    localparam int IN_WP = 5;
    localparam int IN_BVD1 = 6;
    localparam int IN_BVD2 = 7;
    localparam int IN_WAIT = 8;
    localparam int SYNC_W = 2 * IN_W + 2 * DATA_W;

    typedef enum logic [1:0] {PCSS_SEL_CTRL, PCSS_SEL_SLEEP, PCSS_SEL_STATUS, PCSS_SEL_NONE} pcss_sel_t;
endpackage

/* design/pcss_sock_if.sv */
`timescale 1ns/10ps
interface pcss_sock_if;
    logic sleep;
    logic float_n;
    logic sleep_drive;
    logic card_reset;
    logic card_absent;
    modport ctrl (output sleep, output float_n, output sleep_drive, output card_reset, output card_absent);
    modport sock (input sleep, input float_n, input sleep_drive, input card_reset, input card_absent);
endinterface

/* design/pcss_sync.sv */
`timescale 1ns/10ps
module pcss_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* design/pcss_sock_drive.sv */
`timescale 1ns/10ps
module pcss_sock_drive #(
    parameter int ADDR_W = 26,
    parameter logic SEL_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    pcss_sock_if.sock ctl,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [pcss_pkg::DATA_W-1:0] host_wdata,
    input wire logic [pcss_pkg::STB_W-1:0] host_strobe_n,
    input wire logic host_sock_sel,
    output logic [pcss_pkg::DATA_W-1:0] data_o,
    output logic data_oe,
    output logic [ADDR_W-1:0] addr_o,
    output logic addr_oe,
    output logic [pcss_pkg::STB_W-1:0] strobe_n,
    output logic strobe_oe,
    output logic reset_o,
    output logic reset_oe
);
    logic selected;
    logic present;
    logic ce_idle;

    assign selected = host_sock_sel == SEL_VAL;
    assign present = !ctl.card_absent;
    assign ce_idle = host_strobe_n[pcss_pkg::STB_CE1] && host_strobe_n[pcss_pkg::STB_CE2];

    // Bus pins
    always_ff @(posedge clk)
    begin
        if (rst || !ctl.float_n)
        begin
            data_o <= '0;
            data_oe <= 1'b0;
            addr_o <= '0;
            addr_oe <= 1'b0;
        end
        else if (ctl.sleep)
        begin
            data_o <= '0;
            data_oe <= ctl.sleep_drive;
            addr_o <= '0;
            addr_oe <= ctl.sleep_drive;
        end
        else
        begin
            data_o <= host_wdata;
            // Released while the card is being read so it can drive back
            data_oe <= present && selected && host_strobe_n[pcss_pkg::STB_IOR] && host_strobe_n[pcss_pkg::STB_OE];
            addr_o <= (selected && !ce_idle) ? host_addr : '0;
            addr_oe <= present;
        end
    end

    // Strobes and card reset
    always_ff @(posedge clk)
    begin
        if (rst || !ctl.float_n)
        begin
            strobe_n <= '1;
            strobe_oe <= 1'b0;
            reset_o <= 1'b0;
            reset_oe <= 1'b0;
        end
        else if (ctl.sleep)
        begin
            strobe_n <= '1;
            strobe_oe <= ctl.sleep_drive;
            reset_o <= 1'b0;
            reset_oe <= ctl.sleep_drive;
        end
        else
        begin
            strobe_n <= (present && selected) ? host_strobe_n : '1;
            strobe_oe <= 1'b1;
            reset_o <= ctl.card_reset;
            reset_oe <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_float_all_off: assert property (!ctl.float_n |=> !data_oe && !addr_oe && !strobe_oe && !reset_oe)
        else $error("floated socket still drives a pin");
    chk_sleep_bus_low: assert property (ctl.float_n && ctl.sleep && ctl.sleep_drive
        |=> data_oe && addr_oe && data_o == '0 && addr_o == '0)
        else $error("sleep drive did not pull the buses low");
    chk_sleep_bus_float: assert property (ctl.float_n && ctl.sleep && !ctl.sleep_drive
        |=> !data_oe && !addr_oe && !strobe_oe && !reset_oe)
        else $error("sleep float left a pin driven");
    chk_sleep_strobe_high: assert property (ctl.float_n && ctl.sleep && ctl.sleep_drive
        |=> strobe_oe && strobe_n == '1)
        else $error("sleep drive did not hold strobes high");
    chk_sleep_reset_pin: assert property (ctl.float_n && ctl.sleep
        |=> reset_oe == $past(ctl.sleep_drive) && !reset_o)
        else $error("card reset wrong in sleep");
endmodule

/* design/pcss_top.sv */
`timescale 1ns/10ps
module pcss_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [pcss_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [pcss_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [pcss_pkg::AXI_SW-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcss_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [pcss_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_in,
    input wire logic [pcss_pkg::HOST_AW-1:0] host_addr,
    input wire logic [pcss_pkg::DATA_W-1:0] host_wdata,
    input wire logic [pcss_pkg::STB_W-1:0] host_strobe_n,
    input wire logic host_sock_sel,
    output logic host_wait_out_n,
    output logic [pcss_pkg::DATA_W-1:0] host_card_rdata,
    output logic [1:0] card_voltage_select,
    input wire logic [pcss_pkg::IN_W-1:0] sock0_card_in,
    input wire logic [pcss_pkg::IN_W-1:0] sock1_card_in,
    input wire logic [pcss_pkg::DATA_W-1:0] sock0_data_in,
    output logic [pcss_pkg::DATA_W-1:0] sock0_data_o,
    output logic sock0_data_oe,
    output logic [pcss_pkg::S0_AW-1:0] sock0_addr_o,
    output logic sock0_addr_oe,
    output logic [pcss_pkg::STB_W-1:0] sock0_strobe_n,
    output logic sock0_strobe_oe,
    output logic sock0_reset_o,
    output logic sock0_reset_oe,
    input wire logic [pcss_pkg::DATA_W-1:0] sock1_data_in,
    output logic [pcss_pkg::DATA_W-1:0] sock1_data_o,
    output logic sock1_data_oe,
    output logic [pcss_pkg::S1_AW-1:0] sock1_addr_o,
    output logic sock1_addr_oe,
    output logic [pcss_pkg::STB_W-1:0] sock1_strobe_n,
    output logic sock1_strobe_oe,
    output logic sock1_reset_o,
    output logic sock1_reset_oe
);
    // No power-switch pins here: those belong to the GPIO port

    logic [pcss_pkg::CTRL_W-1:0] ctrl_reg;
    logic [pcss_pkg::SLEEP_W-1:0] sleep_reg;
    logic [pcss_pkg::STATUS_W-1:0] status_reg;
    logic [pcss_pkg::SYNC_W-1:0] sync_q;
    logic [pcss_pkg::IN_W-1:0] s0_in;
    logic [pcss_pkg::IN_W-1:0] s1_in;
    logic [pcss_pkg::DATA_W-1:0] s0_rd;
    logic [pcss_pkg::DATA_W-1:0] s1_rd;

    logic aw_full_reg;
    logic w_full_reg;
    logic [pcss_pkg::AXI_AW-1:0] aw_addr_reg;
    logic [pcss_pkg::AXI_DW-1:0] w_data_reg;
    logic [pcss_pkg::AXI_SW-1:0] w_strb_reg;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_go;
    pcss_pkg::pcss_sel_t wr_sel;
    pcss_pkg::pcss_sel_t rd_sel;

    function automatic pcss_pkg::pcss_sel_t pcss_decode(input logic [pcss_pkg::AXI_AW-1:0] addr);
        pcss_pkg::pcss_sel_t sel;
        if (addr[pcss_pkg::AXI_AW-1:2] == pcss_pkg::OFF_CTRL[pcss_pkg::AXI_AW-1:2])
            sel = pcss_pkg::PCSS_SEL_CTRL;
        else if (addr[pcss_pkg::AXI_AW-1:2] == pcss_pkg::OFF_SLEEP[pcss_pkg::AXI_AW-1:2])
            sel = pcss_pkg::PCSS_SEL_SLEEP;
        else if (addr[pcss_pkg::AXI_AW-1:2] == pcss_pkg::OFF_STATUS[pcss_pkg::AXI_AW-1:2])
            sel = pcss_pkg::PCSS_SEL_STATUS;
        else
            sel = pcss_pkg::PCSS_SEL_NONE;
        return sel;
    endfunction

    // Card pins are asynchronous to clk
    pcss_sync #(
        .WIDTH(pcss_pkg::SYNC_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d({sock1_data_in, sock0_data_in, sock1_card_in, sock0_card_in}),
        .q(sync_q)
    );

    assign {s1_rd, s0_rd, s1_in, s0_in} = sync_q;

    // Write address and data are taken independently, then applied together
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_sel = pcss_decode(aw_addr_reg);
    assign rd_sel = pcss_decode(s_axi_araddr);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_full_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr_reg <= '0;
        end
        else
        begin
            if (aw_hs)
                aw_addr_reg <= s_axi_awaddr;
            aw_full_reg <= (aw_full_reg && !wr_go) || aw_hs;
            s_axi_awready <= aw_full_reg ? wr_go : !aw_hs;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            w_full_reg <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end
        else
        begin
            if (w_hs)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            w_full_reg <= (w_full_reg && !wr_go) || w_hs;
            s_axi_wready <= w_full_reg ? wr_go : !w_hs;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pcss_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            // Status writes are accepted quietly; only holes in the map get an error
            s_axi_bresp <= (wr_sel == pcss_pkg::PCSS_SEL_NONE) ? pcss_pkg::RESP_SLVERR : pcss_pkg::RESP_OKAY;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Only byte lane 0 holds writable bits
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_reg <= pcss_pkg::CTRL_RESET;
        else if (wr_go && wr_sel == pcss_pkg::PCSS_SEL_CTRL && w_strb_reg[0])
            ctrl_reg <= w_data_reg[pcss_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            sleep_reg <= pcss_pkg::SLEEP_RESET;
        else if (wr_go && wr_sel == pcss_pkg::PCSS_SEL_SLEEP && w_strb_reg[0])
            sleep_reg <= w_data_reg[pcss_pkg::SLEEP_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            status_reg <= pcss_pkg::STATUS_RESET;
        else
        begin
            status_reg[pcss_pkg::ST_RDY0] <= s0_in[pcss_pkg::IN_RDY];
            status_reg[pcss_pkg::ST_RDY1] <= s1_in[pcss_pkg::IN_RDY];
            status_reg[pcss_pkg::ST_CDV0] <= s0_in[pcss_pkg::IN_CD1] || s0_in[pcss_pkg::IN_CD2];
            status_reg[pcss_pkg::ST_CDV1] <= s1_in[pcss_pkg::IN_CD1] || s1_in[pcss_pkg::IN_CD2];
            status_reg[pcss_pkg::ST_VS1_0] <= s0_in[pcss_pkg::IN_VS1];
            status_reg[pcss_pkg::ST_VS2_0] <= s0_in[pcss_pkg::IN_VS2];
            status_reg[pcss_pkg::ST_VS1_1] <= s1_in[pcss_pkg::IN_VS1];
            status_reg[pcss_pkg::ST_VS2_1] <= s1_in[pcss_pkg::IN_VS2];
            status_reg[pcss_pkg::ST_WP0] <= s0_in[pcss_pkg::IN_WP];
            status_reg[pcss_pkg::ST_WP1] <= s1_in[pcss_pkg::IN_WP];
            status_reg[pcss_pkg::ST_BVD1_0] <= s0_in[pcss_pkg::IN_BVD1];
            status_reg[pcss_pkg::ST_BVD2_0] <= s0_in[pcss_pkg::IN_BVD2];
            status_reg[pcss_pkg::ST_BVD1_1] <= s1_in[pcss_pkg::IN_BVD1];
            status_reg[pcss_pkg::ST_BVD2_1] <= s1_in[pcss_pkg::IN_BVD2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= pcss_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !ar_hs && (!s_axi_rvalid || s_axi_rready);
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= '0;
                s_axi_rresp <= pcss_pkg::RESP_OKAY;
                if (rd_sel == pcss_pkg::PCSS_SEL_CTRL)
                    s_axi_rdata[pcss_pkg::CTRL_W-1:0] <= ctrl_reg;
                else if (rd_sel == pcss_pkg::PCSS_SEL_SLEEP)
                    s_axi_rdata[pcss_pkg::SLEEP_W-1:0] <= sleep_reg;
                else if (rd_sel == pcss_pkg::PCSS_SEL_STATUS)
                    s_axi_rdata[pcss_pkg::STATUS_W-1:0] <= status_reg;
                else
                    s_axi_rresp <= pcss_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Host-side wait and read-back paths
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            host_wait_out_n <= 1'b1;
            host_card_rdata <= '0;
        end
        else
        begin
            host_wait_out_n <= !((ctrl_reg[pcss_pkg::C_WAIT0] && !s0_in[pcss_pkg::IN_WAIT])
                || (ctrl_reg[pcss_pkg::C_WAIT1] && !s1_in[pcss_pkg::IN_WAIT]));
            host_card_rdata <= host_sock_sel ? s1_rd : s0_rd;
        end
    end

    assign card_voltage_select = ctrl_reg[pcss_pkg::C_VSEL_HI:pcss_pkg::C_VSEL_LO];

    pcss_sock_if sock0_ctl ();
    pcss_sock_if sock1_ctl ();

    // Sleep is taken unregistered so the pin registers switch on the next edge
    assign sock0_ctl.sleep = sleep_in;
    assign sock1_ctl.sleep = sleep_in;
    assign sock0_ctl.float_n = ctrl_reg[pcss_pkg::C_FLT0];
    assign sock1_ctl.float_n = ctrl_reg[pcss_pkg::C_FLT1];
    assign sock0_ctl.sleep_drive = sleep_reg[pcss_pkg::SL_SOCK0];
    assign sock1_ctl.sleep_drive = sleep_reg[pcss_pkg::SL_SOCK1];
    assign sock0_ctl.card_reset = ctrl_reg[pcss_pkg::C_RST0];
    assign sock1_ctl.card_reset = ctrl_reg[pcss_pkg::C_RST1];
    assign sock0_ctl.card_absent = s0_in[pcss_pkg::IN_CD1] || s0_in[pcss_pkg::IN_CD2];
    assign sock1_ctl.card_absent = s1_in[pcss_pkg::IN_CD1] || s1_in[pcss_pkg::IN_CD2];

    pcss_sock_drive #(
        .ADDR_W(pcss_pkg::S0_AW),
        .SEL_VAL(1'b0)
    ) u_sock0 (
        .clk(clk),
        .rst(rst),
        .ctl(sock0_ctl),
        .host_addr(host_addr[pcss_pkg::S0_AW-1:0]),
        .host_wdata(host_wdata),
        .host_strobe_n(host_strobe_n),
        .host_sock_sel(host_sock_sel),
        .data_o(sock0_data_o),
        .data_oe(sock0_data_oe),
        .addr_o(sock0_addr_o),
        .addr_oe(sock0_addr_oe),
        .strobe_n(sock0_strobe_n),
        .strobe_oe(sock0_strobe_oe),
        .reset_o(sock0_reset_o),
        .reset_oe(sock0_reset_oe)
    );

    pcss_sock_drive #(
        .ADDR_W(pcss_pkg::S1_AW),
        .SEL_VAL(1'b1)
    ) u_sock1 (
        .clk(clk),
        .rst(rst),
        .ctl(sock1_ctl),
        .host_addr(host_addr[pcss_pkg::S1_AW-1:0]),
        .host_wdata(host_wdata),
        .host_strobe_n(host_strobe_n),
        .host_sock_sel(host_sock_sel),
        .data_o(sock1_data_o),
        .data_oe(sock1_data_oe),
        .addr_o(sock1_addr_o),
        .addr_oe(sock1_addr_oe),
        .strobe_n(sock1_strobe_n),
        .strobe_oe(sock1_strobe_oe),
        .reset_o(sock1_reset_o),
        .reset_oe(sock1_reset_oe)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_wait_pass_one: assert property (ctrl_reg[pcss_pkg::C_WAIT1] && !s1_in[pcss_pkg::IN_WAIT]
        |=> !host_wait_out_n)
        else $error("socket 1 wait not passed to host");
    chk_volt_select_wr: assert property (wr_go && wr_sel == pcss_pkg::PCSS_SEL_CTRL && w_strb_reg[0]
        |=> card_voltage_select == $past(w_data_reg[pcss_pkg::C_VSEL_HI:pcss_pkg::C_VSEL_LO]))
        else $error("voltage select not updated by control write");
    chk_ctrl_wr_resp: assert property (wr_go && wr_sel == pcss_pkg::PCSS_SEL_CTRL
        |=> s_axi_bvalid && s_axi_bresp == pcss_pkg::RESP_OKAY)
        else $error("control write not answered OKAY");
    chk_sleep_wr_value: assert property (wr_go && wr_sel == pcss_pkg::PCSS_SEL_SLEEP && w_strb_reg[0]
        |=> sleep_reg == $past(w_data_reg[pcss_pkg::SLEEP_W-1:0]))
        else $error("sleep state write lost");
    chk_status_wr_none: assert property (wr_go && wr_sel == pcss_pkg::PCSS_SEL_STATUS
        |=> $stable(ctrl_reg) && $stable(sleep_reg) && s_axi_bresp == pcss_pkg::RESP_OKAY)
        else $error("status write had an effect");
    chk_unmapped_read: assert property (ar_hs && rd_sel == pcss_pkg::PCSS_SEL_NONE
        |=> s_axi_rvalid && s_axi_rresp == pcss_pkg::RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    chk_sock0_sleep_low: assert property (sleep_in && ctrl_reg[pcss_pkg::C_FLT0] && sleep_reg[pcss_pkg::SL_SOCK0]
        |=> sock0_addr_oe && sock0_addr_o == '0)
        else $error("socket 0 not driven low one edge after sleep");
    chk_sock1_sleep_own: assert property (sleep_in && ctrl_reg[pcss_pkg::C_FLT1] && !sleep_reg[pcss_pkg::SL_SOCK1]
        |=> !sock1_strobe_oe && !sock1_reset_oe)
        else $error("socket 1 sleep float not taken from its own bit");
    chk_sleep_leave: assert property ($fell(sleep_in) && ctrl_reg[pcss_pkg::C_FLT0]
        |=> sock0_strobe_oe && sock0_reset_oe)
        else $error("socket 0 did not return to normal drive");

    cov_ctrl_write: cover property (wr_go && wr_sel == pcss_pkg::PCSS_SEL_CTRL);
    cov_status_read: cover property (ar_hs && rd_sel == pcss_pkg::PCSS_SEL_STATUS);
    cov_sleep_drive: cover property (sleep_in && sleep_reg == 2'h3 && ctrl_reg[pcss_pkg::C_FLT0]);
    cov_host_wait: cover property (!host_wait_out_n);
endmodule

/* testbench/pcss_card_model.sv */
`timescale 1ns/10ps
module pcss_card_model (
    input wire logic clk,
    input wire logic wait_req,
    input wire logic data_oe,
    output logic [8:0] card_in,
    output logic [15:0] data_in
);
    // Card seated (detect lines low) and ready; wait pin is active low
    assign card_in = {~wait_req, 8'h01};
    logic [15:0] bus_q = 16'ha5c3;
    // Undriven bus keeps toggling so a stale value can never pass as driven
    always @(posedge clk)
        bus_q <= data_oe ? 16'h0000 : ~bus_q;
    assign data_in = bus_q;
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_in, host_sock_sel, host_wait_out_n;
    logic [15:0] s_axi_awaddr, s_axi_araddr, host_wdata, host_card_rdata, rnd;
    logic [15:0] sock0_data_in, sock0_data_o, sock1_data_in, sock1_data_o;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, card_voltage_select;
    logic [25:0] host_addr, sock0_addr_o;
    logic [10:0] sock1_addr_o;
    logic [6:0] host_strobe_n, sock0_strobe_n, sock1_strobe_n;
    logic [8:0] sock0_card_in, sock1_card_in;
    logic sock0_data_oe, sock0_addr_oe, sock0_strobe_oe, sock0_reset_o, sock0_reset_oe, wait1;
    logic sock1_data_oe, sock1_addr_oe, sock1_strobe_oe, sock1_reset_o, sock1_reset_oe;
    int unsigned mdl[2];
    int n_errors = 0;
    int cmp_count = 0;
    pcss_top uut (.*);
    pcss_card_model c0 (.clk(clk), .wait_req(1'b0), .data_oe(sock0_data_oe), .card_in(sock0_card_in),
        .data_in(sock0_data_in));
    pcss_card_model c1 (.clk(clk), .wait_req(wait1), .data_oe(sock1_data_oe), .card_in(sock1_card_in),
        .data_in(sock1_data_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [33:0] exp_rd(input logic [15:0] a);
        case (a)
            pcss_pkg::OFF_CTRL: return {2'h0, mdl[0] & 32'hff};
            pcss_pkg::OFF_SLEEP: return {2'h0, mdl[1] & 32'h3};
            pcss_pkg::OFF_STATUS: return 34'h3;
            default: return {pcss_pkg::RESP_SLVERR, 32'h0};
        endcase
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [33:0] e;
        e = exp_rd(a);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, e[33:32]);
        if (a == pcss_pkg::OFF_CTRL && s_axi_wstrb[0])
            mdl[0] = d;
        if (a == pcss_pkg::OFF_SLEEP && s_axi_wstrb[0])
            mdl[1] = d;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk({s_axi_rresp, s_axi_rdata}, exp_rd(a));
    endtask
    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (rst)
        begin
            rnd <= 16'h003b;
            {host_addr, host_wdata, host_strobe_n, host_sock_sel} <= '0;
        end
        else
        begin
            rnd <= lfsr(rnd);
            host_addr <= {rnd, rnd[9:0]};
            host_wdata <= ~rnd;
            host_strobe_n <= rnd[6:0];
            host_sock_sel <= rnd[15];
        end
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict;
    end
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_in, wait1} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(pcss_pkg::OFF_CTRL);
        rd(pcss_pkg::OFF_SLEEP);
        // Float bits kept set so the sleep drive is visible at the pins
        for (int i = 0; i < 4; i++)
        begin
            wr(pcss_pkg::OFF_CTRL, {rnd, rnd[15:8], rnd[7:4], 4'hc});
            rd(pcss_pkg::OFF_CTRL);
            chk(card_voltage_select, mdl[0][7:6]);
            wr(pcss_pkg::OFF_SLEEP, {rnd, 14'h0, i[1:0]});
            rd(pcss_pkg::OFF_SLEEP);
            sleep_in <= 1'b1;
            repeat (3) @(posedge clk);
            chk({sock0_data_oe, sock0_addr_oe, sock0_strobe_oe, sock0_reset_oe}, {4{i[0]}});
            chk({sock1_data_oe, sock1_addr_oe, sock1_strobe_oe, sock1_reset_oe}, {4{i[1]}});
            if (i[0])
                chk({sock0_data_o, sock0_addr_o, sock0_strobe_n, sock0_reset_o}, 64'hfe);
            if (i[1])
                chk({sock1_data_o, sock1_addr_o, sock1_strobe_n, sock1_reset_o}, 64'hfe);
            // Both buses held low, so the card read-back path must show zero after its sync delay
            if (i == 3)
            begin
                repeat (3) @(posedge clk);
                chk(host_card_rdata, 0);
            end
            sleep_in <= 1'b0;
        end
        // Lane 0 strobe low: the write is answered but changes nothing
        s_axi_wstrb <= 4'he;
        wr(pcss_pkg::OFF_SLEEP, 32'h0);
        s_axi_wstrb <= 4'hf;
        rd(pcss_pkg::OFF_SLEEP);
        wr(pcss_pkg::OFF_STATUS, {rnd, rnd});
        rd(pcss_pkg::OFF_STATUS);
        wr(16'h180c, 32'hffffffff);
        rd(16'h180c);
        wr(pcss_pkg::OFF_CTRL, 32'h20);
        wait1 <= 1'b1;
        sleep_in <= 1'b1;
        repeat (5) @(posedge clk);
        chk({sock0_data_oe, sock0_addr_oe, sock0_strobe_oe, sock0_reset_oe,
            sock1_data_oe, sock1_addr_oe, sock1_strobe_oe, sock1_reset_oe}, 0);
        sleep_in <= 1'b0;
        repeat (5) @(posedge clk);
        chk(host_wait_out_n, 0);
        wr(pcss_pkg::OFF_CTRL, 32'h0c);
        repeat (5) @(posedge clk);
        chk(host_wait_out_n, 1);
        // Mid-run reset must bring both writable registers back to zero
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mdl = '{0, 0};
        rd(pcss_pkg::OFF_CTRL);
        rd(pcss_pkg::OFF_SLEEP);
        give_verdict;
    end
endmodule
